// ### include/cpa_regs.svh
// Register offsets, field positions, reset values and step counts of the coefficient pointer unit
`ifndef CPA_REGS_SVH
`define CPA_REGS_SVH

`define CPA_ADDR_W          8
`define CPA_DATA_W          16

`define CPA_OFS_PTR_LOW     8'h00
`define CPA_OFS_PTR_HIGH    8'h04
`define CPA_OFS_BUF_START   8'h08
`define CPA_OFS_BUF_SIZE    8'h0C
`define CPA_OFS_STATUS2     8'h10
`define CPA_OFS_REJECTS     8'h14

`define CPA_RST_PTR_LOW     16'h0000
`define CPA_RST_PTR_HIGH    7'h00
`define CPA_RST_BUF_START   16'h0000
`define CPA_RST_BUF_SIZE    16'h0000
`define CPA_RST_CIRC        1'b0

`define CPA_CIRC_BIT        4

`define CPA_STEP_SINGLE     23'h00_0001
`define CPA_STEP_DOUBLE     23'h00_0002

`define CPA_ACC_LAST        3'h3
`define CPA_AUX_LAST        3'h7
`define CPA_TMP_LAST        3'h3

`endif

// ### include/cpa_pkg.sv
// Types shared by the coefficient pointer unit and its bit access checker
package cpa_pkg;

  typedef enum logic [1:0] {
    CPA_ACC_DATA = 2'b00,
    CPA_ACC_MMR  = 2'b01,
    CPA_ACC_BIT  = 2'b10,
    CPA_ACC_IO   = 2'b11
  } cpa_access_type;

  typedef enum logic [0:0] {
    CPA_FORM_PLAIN   = 1'b0,
    CPA_FORM_POSTINC = 1'b1
  } cpa_form_type;

  typedef enum logic [2:0] {
    CPA_OP_NONE  = 3'b000,
    CPA_OP_TEST  = 3'b001,
    CPA_OP_SET   = 3'b010,
    CPA_OP_CLEAR = 3'b011,
    CPA_OP_CPL   = 3'b100
  } cpa_bitop_type;

  typedef enum logic [1:0] {
    CPA_TGT_ACCUM = 2'b00,
    CPA_TGT_AUX   = 2'b01,
    CPA_TGT_TEMP  = 2'b10,
    CPA_TGT_OTHER = 2'b11
  } cpa_target_type;

  typedef struct packed {
    logic           valid;
    cpa_access_type access;
    cpa_form_type   form;
    logic           wide;
    cpa_bitop_type  bit_op;
    cpa_target_type target;
    logic [2:0]     target_idx;
  } cpa_req_type;

  typedef struct packed {
    logic        valid;
    logic        mmr;
    logic        wide;
    logic [22:0] addr;
  } cpa_data_bus_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } cpa_io_bus_type;

  typedef struct packed {
    logic           valid;
    logic           pair;
    cpa_bitop_type  bit_op;
    cpa_target_type target;
    logic [2:0]     target_idx;
    logic [15:0]    bit_num;
  } cpa_bit_bus_type;

endpackage : cpa_pkg

// ### src/cpa_bit_check.sv
// Legality check for register-bit accesses through the coefficient pointer
`timescale 1ns/100ps
`default_nettype none
`include "cpa_regs.svh"

module cpa_bit_check
  import cpa_pkg::*;
(
  input  wire cpa_req_type req,
  output logic             legal
);

  logic op_ok;
  logic tgt_ok;

  always_comb begin
    op_ok = (req.bit_op == CPA_OP_TEST) || (req.bit_op == CPA_OP_SET) ||
            (req.bit_op == CPA_OP_CLEAR) || (req.bit_op == CPA_OP_CPL); // R5
    case (req.target)
      CPA_TGT_ACCUM: tgt_ok = (req.target_idx <= `CPA_ACC_LAST); // R6
      CPA_TGT_AUX:   tgt_ok = (req.target_idx <= `CPA_AUX_LAST); // R6
      CPA_TGT_TEMP:  tgt_ok = (req.target_idx <= `CPA_TMP_LAST); // R6
      default:       tgt_ok = 1'b0;
    endcase
    legal = op_ok && tgt_ok;
  end

endmodule : cpa_bit_check
`default_nettype wire

// ### src/cpa_agu.sv
// Coefficient pointer address generation: data, register-bit and I/O space
//
// Behaviour
// R1 - Pointer means address low half, bit number or I/O address by access type.
// R2 - Data address is seven high bits joined with sixteen pointer bits.
// R3 - Data addresses serve both data memory and memory-mapped registers.
// R4 - For bit access the pointer value is the bit index, zero is LSB.
// R5 - Bit access allowed only for test, set, clear, complement.
// R6 - Bit access targets only accumulators, auxiliary and temporary registers.
// R7 - I/O address is the whole sixteen-bit pointer, high part ignored.
// R8 - Update and address linear or circular per second status register.
// R9 - Buffer start added only when circular mode is on.
// R10 - Address arithmetic spans the full 23-bit extended pointer.
// R11 - Software must not rely on wrap past top or bottom.
// R12 - Software keeps circular sum at or below top of data space.
// R13 - Plain form leaves pointer unchanged for all access types.
// R14 - Post-increment form generates address first, then increments.
// R15 - Step is one for single, two for double or bit pair.
// R16 - Pointer updates wrap modulo two to the twenty-third.
`timescale 1ns/100ps
`default_nettype none
`include "cpa_regs.svh"

module cpa_agu
  import cpa_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [`CPA_ADDR_W-1:0] reg_addr,
  input  wire logic [`CPA_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`CPA_DATA_W-1:0] reg_rdata,
  input  wire cpa_req_type            req,
  output cpa_data_bus_type            data_bus,
  output cpa_io_bus_type              io_bus,
  output cpa_bit_bus_type             bit_bus,
  output logic                        bit_reject
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [15:0]      coef_pointer_low_q;
  logic [6:0]       coef_pointer_high_q;
  logic [15:0]      coef_buffer_start_q;
  logic [15:0]      coef_buffer_size_q;
  logic             circ_enable_q;
  logic [15:0]      reject_count_q;
  logic [15:0]      rdata_q;
  cpa_data_bus_type data_bus_q;
  cpa_io_bus_type   io_bus_q;
  cpa_bit_bus_type  bit_bus_q;
  logic             bit_reject_q;

  logic [22:0]      coef_pointer_extended;
  logic [22:0]      gen_addr;
  logic [22:0]      next_extended;
  logic [22:0]      step;
  logic             bit_legal;
  logic             accept;
  logic             do_update;
  logic             bit_refused;
  logic [15:0]      rdata_d;

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  // Address from pointer; circular adds buffer start across all 23 bits
  function automatic logic [22:0] gen_address(
    input logic [22:0] ext,
    input logic [15:0] start,
    input logic        circ
  );
    logic [22:0] sum;
    sum = ext + {7'h00, start}; // R10
    if (circ)
      gen_address = sum; // R9
    else
      gen_address = ext; // R9
  endfunction : gen_address

  // Next pointer; linear carries into high part, circular wraps in buffer
  function automatic logic [22:0] next_pointer(
    input logic [22:0] ext,
    input logic [22:0] inc,
    input logic [15:0] size,
    input logic        circ
  );
    logic [16:0] low_sum;
    logic [16:0] low_wrap;
    low_sum  = {1'b0, ext[15:0]} + {1'b0, inc[15:0]};
    low_wrap = low_sum - {1'b0, size};
    if (!circ)
      next_pointer = ext + inc; // R16
    else if (low_sum >= {1'b0, size})
      next_pointer = {ext[22:16], low_wrap[15:0]}; // R8
    else
      next_pointer = {ext[22:16], low_sum[15:0]}; // R8
  endfunction : next_pointer

  ////////////////////////////////////////////////////////////////////////
  // Request decode

  assign coef_pointer_extended = {coef_pointer_high_q, coef_pointer_low_q}; // R2

  cpa_bit_check cpa_bit_check_inst (
    .req   (req),
    .legal (bit_legal)
  );

  always_comb begin
    // Step also doubles for a bit pair: wide covers both
    step = req.wide ? `CPA_STEP_DOUBLE : `CPA_STEP_SINGLE; // R15
    gen_addr = gen_address(coef_pointer_extended, coef_buffer_start_q, circ_enable_q);
    next_extended = next_pointer(coef_pointer_extended, step,
                                 coef_buffer_size_q, circ_enable_q);
    accept = req.valid && ((req.access != CPA_ACC_BIT) || bit_legal); // R5
    do_update = accept && (req.form == CPA_FORM_POSTINC); // R13
    bit_refused = req.valid && (req.access == CPA_ACC_BIT) && !bit_legal; // R6
  end

  ////////////////////////////////////////////////////////////////////////
  // Pointer registers; a software write beats an instruction update

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      coef_pointer_low_q <= `CPA_RST_PTR_LOW;
    end else if (reg_wr && reg_addr == `CPA_OFS_PTR_LOW) begin
      coef_pointer_low_q <= reg_wdata;
    end else if (do_update) begin
      coef_pointer_low_q <= next_extended[15:0]; // R14
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      coef_pointer_high_q <= `CPA_RST_PTR_HIGH;
    end else if (reg_wr && reg_addr == `CPA_OFS_PTR_HIGH) begin
      coef_pointer_high_q <= reg_wdata[6:0];
    end else if (do_update) begin
      coef_pointer_high_q <= next_extended[22:16]; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      coef_buffer_start_q <= `CPA_RST_BUF_START;
      coef_buffer_size_q  <= `CPA_RST_BUF_SIZE;
      circ_enable_q       <= `CPA_RST_CIRC;
    end else if (reg_wr) begin
      case (reg_addr)
        `CPA_OFS_BUF_START: coef_buffer_start_q <= reg_wdata;
        `CPA_OFS_BUF_SIZE:  coef_buffer_size_q  <= reg_wdata;
        `CPA_OFS_STATUS2:   circ_enable_q       <= reg_wdata[`CPA_CIRC_BIT]; // R8
        default: begin
        end
      endcase
    end
  end

  // Saturates rather than wraps so a flood of faults stays visible
  // Set wins: a refusal in the clearing cycle is still counted
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reject_count_q <= 16'h0000;
    end else if (reg_wr && reg_addr == `CPA_OFS_REJECTS) begin
      reject_count_q <= {15'h0000, bit_refused};
    end else if (bit_refused && reject_count_q != 16'hFFFF) begin
      reject_count_q <= reject_count_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port

  always_comb begin
    case (reg_addr)
      `CPA_OFS_PTR_LOW:   rdata_d = coef_pointer_low_q;
      `CPA_OFS_PTR_HIGH:  rdata_d = {9'h000, coef_pointer_high_q};
      `CPA_OFS_BUF_START: rdata_d = coef_buffer_start_q;
      `CPA_OFS_BUF_SIZE:  rdata_d = coef_buffer_size_q;
      `CPA_OFS_STATUS2:   rdata_d = {11'h000, circ_enable_q, 4'h0};
      `CPA_OFS_REJECTS:   rdata_d = reject_count_q;
      default:            rdata_d = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address outputs, taken from the pointer before its update

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_bus_q <= '0;
    end else begin
      data_bus_q.valid <= accept && (req.access == CPA_ACC_DATA ||
                                     req.access == CPA_ACC_MMR); // R3
      data_bus_q.mmr   <= req.access == CPA_ACC_MMR; // R3
      data_bus_q.wide  <= req.wide;
      data_bus_q.addr  <= gen_addr; // R2
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      io_bus_q <= '0;
    end else begin
      io_bus_q.valid <= accept && req.access == CPA_ACC_IO; // R1
      io_bus_q.addr  <= coef_pointer_low_q; // R7
    end
  end

  // Bit index is the raw pointer; the register file bounds it by width
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_bus_q    <= '0;
      bit_reject_q <= 1'b0;
    end else begin
      bit_bus_q.valid      <= accept && req.access == CPA_ACC_BIT; // R5
      bit_bus_q.pair       <= req.wide;
      bit_bus_q.bit_op     <= req.bit_op;
      bit_bus_q.target     <= req.target; // R6
      bit_bus_q.target_idx <= req.target_idx;
      bit_bus_q.bit_num    <= coef_pointer_low_q; // R4
      bit_reject_q <= bit_refused; // R6
    end
  end

  assign data_bus   = data_bus_q;
  assign io_bus     = io_bus_q;
  assign bit_bus    = bit_bus_q;
  assign bit_reject = bit_reject_q;
  assign reg_rdata  = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_io_addr;
    req.valid && req.access == CPA_ACC_IO |=>
      io_bus.valid && io_bus.addr == $past(coef_pointer_low_q) && !data_bus.valid;
  endproperty
  a_io_addr: assert property (p_io_addr) else $error("I/O address not the pointer"); // R7

  property p_data_linear;
    req.valid && req.access == CPA_ACC_DATA && !circ_enable_q |=>
      data_bus.valid && data_bus.addr == $past(coef_pointer_extended);
  endproperty
  a_data_linear: assert property (p_data_linear) else $error("Linear data address wrong"); // R2

  property p_data_circ;
    req.valid && req.access == CPA_ACC_DATA && circ_enable_q |=>
      data_bus.addr == $past(coef_pointer_extended) + {7'h00, $past(coef_buffer_start_q)};
  endproperty
  a_data_circ: assert property (p_data_circ) else $error("Circular address wrong"); // R9

  property p_mmr_path;
    req.valid && req.access == CPA_ACC_MMR |=> data_bus.valid && data_bus.mmr;
  endproperty
  a_mmr_path: assert property (p_mmr_path) else $error("Register access missing"); // R3

  property p_plain_hold;
    req.valid && req.form == CPA_FORM_PLAIN && !reg_wr |=>
      $stable(coef_pointer_extended);
  endproperty
  a_plain_hold: assert property (p_plain_hold) else $error("Plain form moved pointer"); // R13

  property p_inc_linear;
    accept && req.form == CPA_FORM_POSTINC && !circ_enable_q && !reg_wr |=>
      coef_pointer_extended == $past(coef_pointer_extended) + ($past(req.wide) ? 23'h00_0002 : 23'h00_0001);
  endproperty
  a_inc_linear: assert property (p_inc_linear) else $error("Increment step wrong"); // R15

  property p_inc_circ_high;
    accept && req.form == CPA_FORM_POSTINC && circ_enable_q && !reg_wr |=>
      $stable(coef_pointer_high_q);
  endproperty
  a_inc_circ_high: assert property (p_inc_circ_high) else $error("Circular changed high"); // R8

  property p_bit_index;
    req.valid && req.access == CPA_ACC_BIT && bit_legal |=>
      bit_bus.valid && bit_bus.bit_num == $past(coef_pointer_low_q) && !bit_reject;
  endproperty
  a_bit_index: assert property (p_bit_index) else $error("Bit index wrong"); // R4

  property p_bit_op_only;
    bit_bus.valid |-> bit_bus.bit_op != CPA_OP_NONE && bit_bus.target != CPA_TGT_OTHER &&
      (bit_bus.target == CPA_TGT_AUX || bit_bus.target_idx <= 3'h3);
  endproperty
  a_bit_op_only: assert property (p_bit_op_only) else $error("Illegal bit access issued"); // R6

  property p_bit_reject;
    req.valid && req.access == CPA_ACC_BIT && req.bit_op == CPA_OP_NONE && !reg_wr |=>
      bit_reject && !bit_bus.valid && $stable(coef_pointer_extended);
  endproperty
  a_bit_reject: assert property (p_bit_reject) else $error("Bad op not refused"); // R5

  property p_reject_move;
    bit_refused && !reg_wr |=>
      bit_reject && !bit_bus.valid && $stable(coef_pointer_extended);
  endproperty
  a_reject_move: assert property (p_reject_move) else $error("Refused access moved pointer"); // R6

  property p_reject_count;
    bit_refused && !reg_wr && reject_count_q != 16'hFFFF |=>
      reject_count_q == $past(reject_count_q) + 16'h0001;
  endproperty
  a_reject_count: assert property (p_reject_count) else $error("Refusal not counted"); // R6

  property p_io_inc;
    accept && req.access == CPA_ACC_IO && req.form == CPA_FORM_POSTINC &&
      !circ_enable_q && !reg_wr |=>
      io_bus.addr == $past(coef_pointer_low_q) && coef_pointer_low_q != $past(coef_pointer_low_q);
  endproperty
  a_io_inc: assert property (p_io_inc) else $error("I/O post-increment order wrong"); // R14

  property p_bit_fields;
    req.valid && req.access == CPA_ACC_BIT && bit_legal |=>
      bit_bus.pair == $past(req.wide) && bit_bus.bit_op == $past(req.bit_op);
  endproperty
  a_bit_fields: assert property (p_bit_fields) else $error("Bit pair or op not passed"); // R15

  c_post_inc_data: cover property (req.valid && req.form == CPA_FORM_POSTINC &&
                                   req.access == CPA_ACC_DATA ##1 data_bus.valid);
  c_circ_wrap: cover property (do_update && circ_enable_q &&
                               next_extended[15:0] < coef_pointer_low_q);
  c_page_cross: cover property (do_update && !circ_enable_q &&
                                next_extended[22:16] != coef_pointer_high_q);
  c_io_access: cover property (io_bus.valid);
  c_bit_reject: cover property (bit_reject);

endmodule : cpa_agu
`default_nettype wire

// ### sim/cpa_bus_sink.sv
// Far-side model of the data, I/O and bit buses: accepts and counts transfers
`timescale 1ns/100ps
`default_nettype none

module cpa_bus_sink
  import cpa_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire cpa_data_bus_type data_bus,
  input  wire cpa_io_bus_type   io_bus,
  input  wire cpa_bit_bus_type  bit_bus,
  output logic [15:0]           xfer_q
);
  ////////////////////////////////////////////////////////////////////////////////
  // No ready on these buses, so every valid pulse is one finished transfer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xfer_q <= 16'h0000;
    end else begin
      xfer_q <= xfer_q + 16'(data_bus.valid) + 16'(io_bus.valid) + 16'(bit_bus.valid);
    end
  end
endmodule : cpa_bus_sink

`default_nettype wire

// ### sim/tb_cpa_agu.sv
// Self-checking bench for the coefficient pointer address unit
`timescale 1ns/100ps
`default_nettype none
`include "cpa_regs.svh"

module tb_cpa_agu
  import cpa_pkg::*;
;
  logic             ref_clk   = 1'b0;
  logic             rst       = 1'b1;
  logic [7:0]       reg_addr  = 8'h00;
  logic [15:0]      reg_wdata = 16'h0000;
  logic             reg_wr    = 1'b0;
  logic             reg_rd    = 1'b0;
  logic [15:0]      reg_rdata;
  cpa_req_type      req       = '0;
  cpa_data_bus_type data_bus;
  cpa_io_bus_type   io_bus;
  cpa_bit_bus_type  bit_bus;
  logic             bit_reject;
  logic [15:0]      xfer_q;
  int               mismatches  = 0;
  int               comparisons = 0;
  logic [7:0]       ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  cpa_bitop_type    ops [4] = '{CPA_OP_TEST, CPA_OP_SET, CPA_OP_CLEAR, CPA_OP_CPL};
  cpa_target_type   tgs [4] = '{CPA_TGT_ACCUM, CPA_TGT_AUX, CPA_TGT_TEMP, CPA_TGT_AUX};
  logic [2:0]       idxs [4] = '{3'h3, 3'h7, 3'h3, 3'h0};

  always #10 ref_clk = ~ref_clk;

  cpa_agu cpa_agu_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .data_bus(data_bus),
    .io_bus(io_bus), .bit_bus(bit_bus), .bit_reject(bit_reject));

  cpa_bus_sink cpa_bus_sink_inst (.ref_clk(ref_clk), .rst(rst), .data_bus(data_bus), .io_bus(io_bus),
    .bit_bus(bit_bus), .xfer_q(xfer_q));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, then fall to zero
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", 32'(exp), 32'(reg_rdata));
    @(posedge ref_clk);
    #1 chk("reg_rdata idle", 32'h0000_0000, 32'(reg_rdata));
  endtask : rd

  task automatic ptr(input logic [22:0] x);
    wr(`CPA_OFS_PTR_HIGH, 16'(x[22:16]));
    wr(`CPA_OFS_PTR_LOW, x[15:0]);
  endtask : ptr

  // Answer comes exactly one cycle after the request edge
  task automatic go(input cpa_access_type acc, input cpa_form_type fm, input logic wide,
                    input cpa_bitop_type op, input cpa_target_type tg, input logic [2:0] idx,
                    input logic [3:0] exp_v);
    @(posedge ref_clk);
    req <= '{1'b1, acc, fm, wide, op, tg, idx};
    @(posedge ref_clk);
    req.valid <= 1'b0;
    #1 chk("valids", 32'(exp_v), 32'({data_bus.valid, io_bus.valid, bit_bus.valid, bit_reject}));
  endtask : go

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    stop_test;
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 16'h0000);
    // Start set while linear, so any stray addition shows
    wr(`CPA_OFS_BUF_START, 16'h0100);
    wr(`CPA_OFS_BUF_SIZE, 16'h0010);
    ptr(23'h00_FFFF);
    go(CPA_ACC_DATA, CPA_FORM_POSTINC, 1'b0, CPA_OP_NONE, CPA_TGT_OTHER, 3'h0, 4'b1000);
    chk("data addr", 32'h0000_FFFF, 32'(data_bus.addr));
    chk("data mmr", 32'h0000_0000, 32'(data_bus.mmr));
    chk("data wide", 32'h0000_0000, 32'(data_bus.wide));
    rd(`CPA_OFS_PTR_LOW, 16'h0000);
    rd(`CPA_OFS_PTR_HIGH, 16'h0001);
    go(CPA_ACC_MMR, CPA_FORM_PLAIN, 1'b1, CPA_OP_NONE, CPA_TGT_OTHER, 3'h0, 4'b1000);
    chk("mmr addr", 32'h0001_0000, 32'(data_bus.addr));
    chk("mmr flag", 32'h0000_0001, 32'(data_bus.mmr));
    chk("mmr wide", 32'h0000_0001, 32'(data_bus.wide));
    rd(`CPA_OFS_PTR_LOW, 16'h0000);
    wr(`CPA_OFS_PTR_LOW, 16'h1234);
    go(CPA_ACC_IO, CPA_FORM_PLAIN, 1'b0, CPA_OP_NONE, CPA_TGT_OTHER, 3'h0, 4'b0100);
    chk("io addr", 32'h0000_1234, 32'(io_bus.addr));
    go(CPA_ACC_IO, CPA_FORM_POSTINC, 1'b1, CPA_OP_NONE, CPA_TGT_OTHER, 3'h0, 4'b0100);
    chk("io addr inc", 32'h0000_1234, 32'(io_bus.addr));
    rd(`CPA_OFS_PTR_LOW, 16'h1236);
    for (int i = 0; i < 4; i++) begin
      go(CPA_ACC_BIT, CPA_FORM_PLAIN, 1'(i), ops[i], tgs[i], idxs[i], 4'b0010);
      chk("bit num", 32'h0000_1236, 32'(bit_bus.bit_num));
      chk("bit op", 32'(ops[i]), 32'(bit_bus.bit_op));
      chk("bit target", 32'(tgs[i]), 32'(bit_bus.target));
      chk("bit idx", 32'(idxs[i]), 32'(bit_bus.target_idx));
    end
    // Refused bit accesses must neither move the pointer nor reach the bus
    go(CPA_ACC_BIT, CPA_FORM_POSTINC, 1'b0, CPA_OP_NONE, CPA_TGT_ACCUM, 3'h0, 4'b0001);
    go(CPA_ACC_BIT, CPA_FORM_POSTINC, 1'b0, CPA_OP_SET, CPA_TGT_OTHER, 3'h0, 4'b0001);
    go(CPA_ACC_BIT, CPA_FORM_POSTINC, 1'b0, CPA_OP_SET, CPA_TGT_ACCUM, 3'h4, 4'b0001);
    go(CPA_ACC_BIT, CPA_FORM_POSTINC, 1'b0, CPA_OP_TEST, CPA_TGT_TEMP, 3'h4, 4'b0001);
    rd(`CPA_OFS_PTR_LOW, 16'h1236);
    rd(`CPA_OFS_REJECTS, 16'h0004);
    wr(`CPA_OFS_REJECTS, 16'h0000);
    rd(`CPA_OFS_REJECTS, 16'h0000);
    wr(`CPA_OFS_PTR_LOW, 16'h0000);
    go(CPA_ACC_BIT, CPA_FORM_POSTINC, 1'b1, CPA_OP_TEST, CPA_TGT_ACCUM, 3'h0, 4'b0010);
    chk("bit zero", 32'h0000_0000, 32'(bit_bus.bit_num));
    chk("bit pair", 32'h0000_0001, 32'(bit_bus.pair));
    rd(`CPA_OFS_PTR_LOW, 16'h0002);
    wr(`CPA_OFS_STATUS2, 16'h0010);
    rd(`CPA_OFS_STATUS2, 16'h0010);
    ptr(23'h02_000F);
    go(CPA_ACC_DATA, CPA_FORM_POSTINC, 1'b0, CPA_OP_NONE, CPA_TGT_OTHER, 3'h0, 4'b1000);
    chk("circ addr", 32'h0002_010F, 32'(data_bus.addr));
    rd(`CPA_OFS_PTR_LOW, 16'h0000);
    rd(`CPA_OFS_PTR_HIGH, 16'h0002);
    wr(`CPA_OFS_STATUS2, 16'h0000);
    // Wrap checked as a hardware fact only; no later step leans on it
    ptr(23'h7F_FFFF);
    go(CPA_ACC_DATA, CPA_FORM_POSTINC, 1'b1, CPA_OP_NONE, CPA_TGT_OTHER, 3'h0, 4'b1000);
    chk("top addr", 32'h007F_FFFF, 32'(data_bus.addr));
    rd(`CPA_OFS_PTR_LOW, 16'h0001);
    rd(`CPA_OFS_PTR_HIGH, 16'h0000);
    chk("transfers", 32'h0000_000B, 32'(xfer_q));
    stop_test;
  end
endmodule : tb_cpa_agu

`default_nettype wire
